/* File: sim/jtag_ctrl_model.sv */
// Test controller model driving the serial test pins
`timescale 1ns/1ns
module jtag_ctrl_model (
  input wire logic clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic tms_en,
  output logic tdi_en
);
  // Release both pins; undriven lines sit at the pulled-up level
  task automatic park();
    tms = 1'b1;
    tdi = 1'b1;
    tms_en = 1'b0;
    tdi_en = 1'b0;
  endtask

  // Test clock parked low, pins released
  initial begin
    tck = 1'b0;
    park();
  end

  // One test clock period; returns serial output seen just before the rise
  task automatic step(input logic m, input logic d, input logic en, output logic q);
    @(negedge clk);
    tck = 1'b0;
    tms = m;
    tdi = d;
    tms_en = en;
    tdi_en = en;
    repeat (8) @(negedge clk);
    q = tdo;
    tck = 1'b1;
    repeat (7) @(negedge clk);
    park(); // Hold time over, clock stays high with no edge
  endtask
endmodule // jtag_ctrl_model

/* File: sim/testbench.sv */
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ns
`include "tap_regs.svh"
module testbench;
  import tap_pkg::*;
  localparam logic [2:0] REV = 3'h3; // arbitrary value
  localparam logic [16:0] DEV = 17'h1B6E4; // arbitrary value
  localparam logic [10:0] MAK = 11'h1C9; // arbitrary value
  localparam int N = `BSR_CELLS;
  logic clk, reset, tck, tms, tdi, tms_en, tdi_en, tdo, tdo_oe, data_hiz, test_mode;
  logic [N-1:0] pin_in, pin_out;
  instr_t instruction;
  tap_state_t state;
  int miscompares = 0;
  int checks = 0;

  boundary_scan_tap #(.REVISION(REV), .DEVICE_CODE(DEV), .MAKER_CODE(MAK))
    boundary_scan_tap_inst (.clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
    .tms_en(tms_en), .tdi_en(tdi_en), .pin_in(pin_in), .tdo(tdo), .tdo_oe(tdo_oe),
    .data_hiz(data_hiz), .test_mode(test_mode), .pin_out(pin_out),
    .instruction(instruction), .state(state));
  jtag_ctrl_model jtag_ctrl_model_inst (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms),
    .tdi(tdi), .tms_en(tms_en), .tdi_en(tdi_en));

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [N-1:0] got, input logic [N-1:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic stp(input logic m, input logic d, input logic en, output logic q);
    jtag_ctrl_model_inst.step(m, d, en, q);
  endtask

  // Mode-select walk, first step in bit 0
  task automatic walk(input logic [3:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++) stp(seq[i], 1'b1, 1'b1, q);
  endtask

  // From idle: load an instruction lsb first and return to idle
  task automatic go_ir(input instr_t code);
    logic q;
    walk(4'h3, 4);
    for (int i = 0; i < 3; i++) stp(i == 2, code[i], 1'b1, q);
    walk(4'h1, 2);
    check(instruction, code);
  endtask

  // Identity word shifts out lsb first, then serial input follows it
  task automatic id_scn();
    logic [31:0] a, b, d;
    logic q;
    d = 32'hC3A50F96;
    walk(4'h1, 3);
    for (int i = 0; i < 64; i++) begin
      stp(i == 63, d[i % 32], 1'b1, q);
      if (i < 32) a[i] = q;
      else b[i - 32] = q;
    end
    walk(4'h1, 2);
    check(a, {REV, DEV, MAK, 1'b1});
    check(b, d);
  endtask

  // Scan chain: capture of pins, then 107-cell pass-through
  task automatic bsr_scn(input instr_t code, input logic hiz, input logic tm);
    logic [N-1:0] a, b, e;
    logic q;
    go_ir(code);
    check(data_hiz, hiz);
    check(test_mode, tm);
    e = pin_in;
    e[`INTERNAL_CELL] = 1'b0;
    walk(4'h1, 3);
    for (int i = 0; i < 2 * N; i++) begin
      stp(i == 2 * N - 1, ~pin_in[i % N], 1'b1, q);
      if (i == 0) check(tdo_oe, 1'b1);
      if (i < N) a[i] = q;
      else b[i - N] = q;
    end
    walk(4'h1, 2);
    check(a, e);
    check(b, ~pin_in);
    check(tdo_oe, 1'b0);
    check(pin_out, ~pin_in);
  endtask

  // One-bit path: cleared on entry, keeps last bit across pause
  task automatic byp_scn(input instr_t code);
    logic q;
    go_ir(code);
    check(data_hiz, 1'b0);
    walk(4'h1, 3);
    stp(1'b0, 1'b1, 1'b1, q);
    check(q, 1'b0);
    stp(1'b1, 1'b0, 1'b0, q);
    check(q, 1'b1);
    walk(4'h2, 3);
    stp(1'b1, 1'b1, 1'b1, q);
    check(q, 1'b1);
    walk(4'h1, 2);
  endtask

  // Released mode-select reads as 1 and walks the controller to reset
  task automatic rst_scn();
    logic q;
    go_ir(`IR_BYPASS);
    for (int i = 0; i < 5; i++) stp(1'b0, 1'b0, 1'b0, q);
    check(state, st_reset);
    check(instruction, `IR_IDCODE);
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    pin_in = 107'h5A5_1234_5678_9ABC_DEF0_1357_9BDF;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check(state, st_reset);
    check(instruction, `IR_IDCODE);
    check(tdo_oe, 1'b0);
    walk(4'h0, 1);
    id_scn();
    bsr_scn(`IR_EXTEST, 1'b0, 1'b1);
    bsr_scn(`IR_SAMPLE_Z, 1'b1, 1'b0);
    bsr_scn(`IR_SAMPLE_PRELOAD, 1'b0, 1'b0);
    byp_scn(`IR_BYPASS);
    byp_scn(`IR_BYPASS);
    rst_scn();
    report_and_stop();
  end

  // Watchdog on the whole run
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule // testbench

/* File: src/boundary_scan_tap.sv */
// Boundary-scan test access port sampled on the system clock
// Functional notes
// - Holds a 3-bit instruction, 1-bit bypass, 32-bit identity and 107-cell scan chain.
// - Code 000 puts the boundary scan chain between serial input and output.
// - Code 001 puts the 32-bit identity register between serial input and output.
// - Code 010 selects the scan chain and floats the memory data pins.
// - Code 100 selects the scan chain and floats nothing.
// - Code 111 puts the one-bit bypass register in the path.
// - The bypass bit is cleared when the bypass instruction takes effect.
// - The bypass bit keeps the last shifted-in bit after leaving shift.
// - While identity is selected, serial input enters its first stage and shifts through.
// - Identity holds revision in 31:29, device code in 28:12, maker code in 11:1.
// - Identity bit 0 always captures as 1.
// - A sixteen-state controller that resets itself at power-up, no test reset pin.
// - Undriven mode-select and serial input behave as logic 1.
`timescale 1ns/1ns
`include "tap_regs.svh"
module boundary_scan_tap #(
  parameter logic [2:0] REVISION = 3'h5, // arbitrary value
  parameter logic [16:0] DEVICE_CODE = 17'h0ABCD, // arbitrary value
  parameter logic [10:0] MAKER_CODE = 11'h2A5 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tms_en,
  input wire logic tdi_en,
  input wire logic [`BSR_CELLS-1:0] pin_in,
  output logic tdo,
  output logic tdo_oe,
  output logic data_hiz,
  output logic test_mode,
  output logic [`BSR_CELLS-1:0] pin_out,
  output tap_pkg::instr_t instruction,
  output tap_pkg::tap_state_t state
);
  import tap_pkg::*;

  logic tck_s, tms_s, tdi_s, tck_d_r;
  logic tms_en_s, tdi_en_s;
  logic [`BSR_CELLS-1:0] pin_meta_r, pin_sync_r;
  logic tms_v, tdi_v, rise, fall;
  tap_state_t state_r, state_nxt;
  instr_t ir_r, ir_sh_r;
  logic bypass_r;
  logic [`ID_WIDTH-1:0] id_r;
  logic [`BSR_CELLS-1:0] bsr_r, bsr_upd_r;
  logic tdo_nxt;

  // Pin synchronisers
  tap_sync #(.INIT(1'b0)) u_tck (.clk(clk), .reset(reset), .din(tck), .dout(tck_s));
  tap_sync #(.INIT(1'b1)) u_tms (.clk(clk), .reset(reset), .din(tms), .dout(tms_s));
  tap_sync #(.INIT(1'b1)) u_tdi (.clk(clk), .reset(reset), .din(tdi), .dout(tdi_s));
  tap_sync #(.INIT(1'b0)) u_tms_en (.clk(clk), .reset(reset), .din(tms_en),
    .dout(tms_en_s));
  tap_sync #(.INIT(1'b0)) u_tdi_en (.clk(clk), .reset(reset), .din(tdi_en),
    .dout(tdi_en_s));

  // Memory pin levels, two stages before capture
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Undriven inputs read as one
  assign tms_v = tms_en_s ? tms_s : 1'b1;
  assign tdi_v = tdi_en_s ? tdi_s : 1'b1;

  // Test clock edge detection
  always_ff @(posedge clk) begin
    if (reset) tck_d_r <= 1'b0;
    else tck_d_r <= tck_s;
  end
  assign rise = tck_s & ~tck_d_r;
  assign fall = ~tck_s & tck_d_r;

  // Identity word
  function automatic logic [`ID_WIDTH-1:0] id_word();
    logic [`ID_WIDTH-1:0] w;
    w = '0;
    w[`ID_REV_HI:`ID_REV_LO] = REVISION;
    w[`ID_DEV_HI:`ID_DEV_LO] = DEVICE_CODE;
    w[`ID_MFR_HI:`ID_MFR_LO] = MAKER_CODE;
    w[`ID_PRESENT_BIT] = 1'b1;
    return w;
  endfunction

  function automatic logic sel_bsr(input instr_t i);
    return (i == `IR_EXTEST) || (i == `IR_SAMPLE_Z) || (i == `IR_SAMPLE_PRELOAD);
  endfunction

  // Controller next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_reset: state_nxt = tms_v ? st_reset : st_idle;
      st_idle: state_nxt = tms_v ? st_sel_dr : st_idle;
      st_sel_dr: state_nxt = tms_v ? st_sel_ir : st_cap_dr;
      st_cap_dr: state_nxt = tms_v ? st_exit1_dr : st_shift_dr;
      st_shift_dr: state_nxt = tms_v ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: state_nxt = tms_v ? st_upd_dr : st_pause_dr;
      st_pause_dr: state_nxt = tms_v ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: state_nxt = tms_v ? st_upd_dr : st_shift_dr;
      st_upd_dr: state_nxt = tms_v ? st_sel_dr : st_idle;
      st_sel_ir: state_nxt = tms_v ? st_reset : st_cap_ir;
      st_cap_ir: state_nxt = tms_v ? st_exit1_ir : st_shift_ir;
      st_shift_ir: state_nxt = tms_v ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: state_nxt = tms_v ? st_upd_ir : st_pause_ir;
      st_pause_ir: state_nxt = tms_v ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: state_nxt = tms_v ? st_upd_ir : st_shift_ir;
      st_upd_ir: state_nxt = tms_v ? st_sel_dr : st_idle;
    endcase
  end

  // Controller state, self-reset
  always_ff @(posedge clk) begin
    if (reset) state_r <= st_reset;
    else if (rise) state_r <= state_nxt;
  end

  // Instruction shift and update
  always_ff @(posedge clk) begin
    if (reset) begin
      ir_sh_r <= `IR_IDCODE;
      ir_r <= `IR_IDCODE;
    end else if (rise) begin
      if (state_r == st_reset) ir_r <= `IR_IDCODE;
      else if (state_r == st_upd_ir) ir_r <= ir_sh_r;
      if (state_r == st_cap_ir) ir_sh_r <= `IR_CAPTURE_PATTERN;
      else if (state_r == st_shift_ir) ir_sh_r <= {tdi_v, ir_sh_r[`IR_WIDTH-1:1]};
    end
  end

  // Bypass bit
  always_ff @(posedge clk) begin
    if (reset) bypass_r <= 1'b0;
    else if (rise) begin
      if (state_r == st_upd_ir && ir_sh_r == `IR_BYPASS) bypass_r <= 1'b0;
      else if (state_r == st_cap_dr && ir_r == `IR_BYPASS) bypass_r <= 1'b0;
      else if (state_r == st_shift_dr && ir_r == `IR_BYPASS) bypass_r <= tdi_v;
    end
  end

  // Identity register
  always_ff @(posedge clk) begin
    if (reset) id_r <= '0;
    else if (rise && ir_r == `IR_IDCODE) begin
      if (state_r == st_cap_dr) id_r <= id_word();
      else if (state_r == st_shift_dr) id_r <= {tdi_v, id_r[`ID_WIDTH-1:1]};
    end
  end

  // Boundary scan chain, cell 0 nearest the serial output
  always_ff @(posedge clk) begin
    if (reset) begin
      bsr_r <= '0;
      bsr_upd_r <= '0;
    end else if (rise && sel_bsr(ir_r)) begin
      if (state_r == st_cap_dr) begin
        bsr_r <= pin_sync_r;
        bsr_r[`INTERNAL_CELL] <= 1'b0;
      end else if (state_r == st_shift_dr) bsr_r <= {tdi_v, bsr_r[`BSR_CELLS-1:1]};
      else if (state_r == st_upd_dr) bsr_upd_r <= bsr_r;
    end
  end

  // Serial output source
  always_comb begin
    tdo_nxt = bypass_r;
    if (state_r == st_shift_ir) tdo_nxt = ir_sh_r[0];
    else if (ir_r == `IR_IDCODE) tdo_nxt = id_r[0];
    else if (sel_bsr(ir_r)) tdo_nxt = bsr_r[0];
  end

  // Outputs change on the falling test clock
  always_ff @(posedge clk) begin
    if (reset) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (fall) begin
      tdo <= tdo_nxt;
      tdo_oe <= (state_r == st_shift_dr) || (state_r == st_shift_ir);
    end
  end

  // Pin control outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      data_hiz <= 1'b0;
      test_mode <= 1'b0;
      pin_out <= '0;
      instruction <= `IR_IDCODE;
      state <= st_reset;
    end else begin
      data_hiz <= (ir_r == `IR_SAMPLE_Z);
      test_mode <= (ir_r == `IR_EXTEST);
      pin_out <= bsr_upd_r;
      instruction <= ir_r;
      state <= state_r;
    end
  end

  property p_reset_hold;
    @(posedge clk) disable iff (reset)
      (rise && state_r == st_reset && tms_v) |=> state_r == st_reset;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset state left");

  property p_hiz;
    @(posedge clk) disable iff (reset)
      (ir_r == `IR_SAMPLE_Z) [*2] |-> data_hiz;
  endproperty
  a_hiz: assert property (p_hiz) else $error("data pins not floated");

  property p_no_hiz;
    @(posedge clk) disable iff (reset)
      (ir_r == `IR_SAMPLE_PRELOAD) [*2] |-> !data_hiz;
  endproperty
  a_no_hiz: assert property (p_no_hiz) else $error("pins floated in sample");

  property p_byp_clear;
    @(posedge clk) disable iff (reset)
      (rise && state_r == st_upd_ir && ir_sh_r == `IR_BYPASS) |=> !bypass_r;
  endproperty
  a_byp_clear: assert property (p_byp_clear) else $error("bypass not cleared");

  property p_byp_shift;
    @(posedge clk) disable iff (reset)
      (rise && state_r == st_shift_dr && ir_r == `IR_BYPASS) |=> bypass_r == $past(tdi_v);
  endproperty
  a_byp_shift: assert property (p_byp_shift) else $error("bypass missed input");

  property p_byp_keep;
    @(posedge clk) disable iff (reset)
      (state_r inside {st_exit1_dr, st_pause_dr, st_exit2_dr}) |=> $stable(bypass_r);
  endproperty
  a_byp_keep: assert property (p_byp_keep) else $error("bypass changed on exit");

  property p_id_cap;
    @(posedge clk) disable iff (reset)
      (rise && state_r == st_cap_dr && ir_r == `IR_IDCODE) |=>
        id_r == {REVISION, DEVICE_CODE, MAKER_CODE, 1'b1};
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("identity word wrong");

  property p_id_shift;
    @(posedge clk) disable iff (reset)
      (rise && state_r == st_shift_dr && ir_r == `IR_IDCODE) |=>
        id_r[`ID_WIDTH-1] == $past(tdi_v);
  endproperty
  a_id_shift: assert property (p_id_shift) else $error("identity shift wrong");

  property p_bsr_shift;
    @(posedge clk) disable iff (reset)
      (rise && state_r == st_shift_dr && ir_r == `IR_EXTEST) |=>
        bsr_r[`BSR_CELLS-1] == $past(tdi_v);
  endproperty
  a_bsr_shift: assert property (p_bsr_shift) else $error("chain shift wrong");
endmodule // boundary_scan_tap

/* File: src/tap_pkg.sv */
// Types for the boundary-scan test access port
package tap_pkg;
  typedef enum logic [3:0] {
    st_reset = 4'hF,
    st_idle = 4'hC,
    st_sel_dr = 4'h7,
    st_cap_dr = 4'h6,
    st_shift_dr = 4'h2,
    st_exit1_dr = 4'h1,
    st_pause_dr = 4'h3,
    st_exit2_dr = 4'h0,
    st_upd_dr = 4'h5,
    st_sel_ir = 4'h4,
    st_cap_ir = 4'hE,
    st_shift_ir = 4'hA,
    st_exit1_ir = 4'h9,
    st_pause_ir = 4'hB,
    st_exit2_ir = 4'h8,
    st_upd_ir = 4'hD
  } tap_state_t;
  typedef logic [2:0] instr_t;
endpackage

/* File: src/tap_regs.svh */
// Constants for the boundary-scan test access port
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH
`define IR_WIDTH 3
`define ID_WIDTH 32
`define BSR_CELLS 107
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE_Z 3'h2
`define IR_SAMPLE_PRELOAD 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE_PATTERN 3'h1
`define ID_REV_HI 31
`define ID_REV_LO 29
`define ID_DEV_HI 28
`define ID_DEV_LO 12
`define ID_MFR_HI 11
`define ID_MFR_LO 1
`define ID_PRESENT_BIT 0
`define INTERNAL_CELL 47
`endif

/* File: src/tap_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module tap_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  // Two stages, first stage read only by the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= INIT;
      dout <= INIT;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // tap_sync
